/* File: verilog/io_decode_pkg.sv */
// Constants for the I/O-space address decoder: window bounds, target codes.
// Assumes 16-bit word addresses on the I/O space and a single system clock.
// Behaviour
// - Decode a dedicated 64K I/O space
// - Respond only to I/O-space or DMA accesses
// - DMA reaches only I2C, UART, I2S, SD, USB, converter
// - Idle control at 0x0000 to 0x0004
// - Four DMA windows, gaps reserved
// - Three timer windows, gaps reserved
// - RTC window 0x1900 to 0x197F
// - I2C window 0x1A00 to 0x1A6C
// - UART window 0x1B00 to 0x1B1F
// - System control 0x1C00 to 0x1CFF
// - Four audio port windows, offset 0x40 inclusive
// - LCD window 0x2E00 to 0x2E40, full option
// - SPI window 0x3000 to 0x300F
// - Two card windows 0x3A00, 0x3B00
// - Converter window 0x7000 to 0x70FF, full option
// - USB owns 0x8000 to 0xFFFF
// - Reduced option: 0x3B2F to 0x7FFF reserved
package io_decode_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NUM_TGT = 24;
  localparam int TGT_W = 5;

  // Target indices, one select line each
  localparam int T_IDLE = 0;
  localparam int T_DMA0 = 1;
  localparam int T_TMR0 = 5;
  localparam int T_RTC = 8;
  localparam int T_I2C = 9;
  localparam int T_UART = 10;
  localparam int T_SYS = 11;
  localparam int T_AUD0 = 12;
  localparam int T_LCD = 16;
  localparam int T_SPI = 17;
  localparam int T_SD0 = 18;
  localparam int T_SD1 = 19;
  localparam int T_ADC = 20;
  localparam int T_USB = 21;

  localparam logic [15:0] IDLE_LO = 16'h0000;
  localparam logic [15:0] IDLE_HI = 16'h0004;
  localparam logic [15:0] DMA_BASE = 16'h0c00;
  localparam logic [15:0] DMA_STEP = 16'h0100;
  localparam logic [15:0] DMA_SPAN = 16'h007f;
  localparam logic [15:0] TMR_BASE = 16'h1800;
  localparam logic [15:0] TMR_STEP = 16'h0040;
  localparam logic [15:0] TMR_SPAN = 16'h001f;
  localparam logic [15:0] RTC_LO = 16'h1900;
  localparam logic [15:0] RTC_HI = 16'h197f;
  localparam logic [15:0] I2C_LO = 16'h1a00;
  localparam logic [15:0] I2C_HI = 16'h1a6c;
  localparam logic [15:0] UART_LO = 16'h1b00;
  localparam logic [15:0] UART_HI = 16'h1b1f;
  localparam logic [15:0] SYS_LO = 16'h1c00;
  localparam logic [15:0] SYS_HI = 16'h1cff;
  localparam logic [15:0] AUD_BASE = 16'h2800;
  localparam logic [15:0] AUD_STEP = 16'h0100;
  localparam logic [15:0] AUD_SPAN = 16'h0040;
  localparam logic [15:0] LCD_LO = 16'h2e00;
  localparam logic [15:0] LCD_HI = 16'h2e40;
  localparam logic [15:0] SPI_LO = 16'h3000;
  localparam logic [15:0] SPI_HI = 16'h300f;
  localparam logic [15:0] SD_BASE = 16'h3a00;
  localparam logic [15:0] SD_STEP = 16'h0100;
  localparam logic [15:0] SD_SPAN = 16'h001f;
  localparam logic [15:0] ADC_LO = 16'h7000;
  localparam logic [15:0] ADC_HI = 16'h70ff;
  localparam logic [15:0] USB_LO = 16'h8000;

  localparam logic [DATA_W-1:0] RD_ZERO = 16'h0000;
endpackage : io_decode_pkg

/* File: verilog/io_space_address_decoder.sv */
// I/O-space address decoder: registers one access per cycle and raises the
// select line of the owning peripheral window; returns the selected read data.
// Assumes masters issue one-cycle strobes from logic on clk; no stalling.
`timescale 1ns/1ps
module io_space_address_decoder #(
  parameter bit FULL_OPTION = 1'b1 // LCD and converter windows present
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic io_req, // I/O-space instruction or DMA access strobe
  input wire logic io_from_dma,
  input wire logic mem_req, // Ordinary memory access; never decoded here
  input wire logic io_we,
  input wire logic [io_decode_pkg::ADDR_W-1:0] io_addr,
  input wire logic [io_decode_pkg::DATA_W-1:0] io_wdata,
  input wire logic [io_decode_pkg::NUM_TGT*io_decode_pkg::DATA_W-1:0] tgt_rdata,
  output logic [io_decode_pkg::NUM_TGT-1:0] tgt_sel,
  output logic tgt_we,
  output logic [io_decode_pkg::ADDR_W-1:0] tgt_addr,
  output logic [io_decode_pkg::DATA_W-1:0] tgt_wdata,
  output logic io_rvalid,
  output logic [io_decode_pkg::DATA_W-1:0] io_rdata,
  output logic io_miss
);
  localparam int NT = io_decode_pkg::NUM_TGT;
  localparam int DW = io_decode_pkg::DATA_W;

  initial begin
    if (io_decode_pkg::ADDR_W != 16) begin
      $error("I/O space must be 64K, 16-bit word address");
    end
  end

  logic [15:0] a;
  assign a = io_addr;

  function automatic logic in_rng(input logic [15:0] x, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (x >= lo) && (x <= hi);
  endfunction : in_rng

  // Window hits
  logic [NT-1:0] hit;
  assign hit[io_decode_pkg::T_IDLE] =
    in_rng(a, io_decode_pkg::IDLE_LO, io_decode_pkg::IDLE_HI);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dma
      localparam logic [15:0] LO = io_decode_pkg::DMA_BASE + 16'(g) * io_decode_pkg::DMA_STEP;
      assign hit[io_decode_pkg::T_DMA0+g] = in_rng(a, LO, LO + io_decode_pkg::DMA_SPAN);
    end
    for (g = 0; g < 3; g++) begin : g_tmr
      localparam logic [15:0] LO = io_decode_pkg::TMR_BASE + 16'(g) * io_decode_pkg::TMR_STEP;
      assign hit[io_decode_pkg::T_TMR0+g] = in_rng(a, LO, LO + io_decode_pkg::TMR_SPAN);
    end
    for (g = 0; g < 4; g++) begin : g_aud
      localparam logic [15:0] LO = io_decode_pkg::AUD_BASE + 16'(g) * io_decode_pkg::AUD_STEP;
      assign hit[io_decode_pkg::T_AUD0+g] = in_rng(a, LO, LO + io_decode_pkg::AUD_SPAN);
    end
  endgenerate

  assign hit[io_decode_pkg::T_RTC] =
    in_rng(a, io_decode_pkg::RTC_LO, io_decode_pkg::RTC_HI);
  assign hit[io_decode_pkg::T_I2C] =
    in_rng(a, io_decode_pkg::I2C_LO, io_decode_pkg::I2C_HI);
  assign hit[io_decode_pkg::T_UART] =
    in_rng(a, io_decode_pkg::UART_LO, io_decode_pkg::UART_HI);
  assign hit[io_decode_pkg::T_SYS] =
    in_rng(a, io_decode_pkg::SYS_LO, io_decode_pkg::SYS_HI);
  // Reduced option leaves the whole 0x3B2F-0x7FFF stretch reserved
  assign hit[io_decode_pkg::T_LCD] = FULL_OPTION &&
    in_rng(a, io_decode_pkg::LCD_LO, io_decode_pkg::LCD_HI);
  assign hit[io_decode_pkg::T_SPI] =
    in_rng(a, io_decode_pkg::SPI_LO, io_decode_pkg::SPI_HI);
  assign hit[io_decode_pkg::T_SD0] = in_rng(a, io_decode_pkg::SD_BASE,
    io_decode_pkg::SD_BASE + io_decode_pkg::SD_SPAN);
  assign hit[io_decode_pkg::T_SD1] = in_rng(a, io_decode_pkg::SD_BASE + io_decode_pkg::SD_STEP,
    io_decode_pkg::SD_BASE + io_decode_pkg::SD_STEP + io_decode_pkg::SD_SPAN);
  assign hit[io_decode_pkg::T_ADC] = FULL_OPTION &&
    in_rng(a, io_decode_pkg::ADC_LO, io_decode_pkg::ADC_HI);
  assign hit[io_decode_pkg::T_USB] = (a >= io_decode_pkg::USB_LO);
  assign hit[NT-1:io_decode_pkg::T_USB+1] = '0;

  // Windows a DMA controller may reach
  logic [NT-1:0] dma_ok;
  assign dma_ok = (NT'(1) << io_decode_pkg::T_I2C) | (NT'(1) << io_decode_pkg::T_UART)
    | (NT'(4'hf) << io_decode_pkg::T_AUD0) | (NT'(1) << io_decode_pkg::T_SD0)
    | (NT'(1) << io_decode_pkg::T_SD1) | (NT'(1) << io_decode_pkg::T_USB)
    | (NT'(1) << io_decode_pkg::T_ADC);

  // Memory-space accesses never reach this space
  logic take;
  assign take = io_req && !mem_req;

  logic [NT-1:0] nxt_sel;
  assign nxt_sel = take ? (hit & (io_from_dma ? dma_ok : '1)) : '0;

  // A miss is a reserved address or a DMA into a barred window
  logic nxt_miss;
  assign nxt_miss = take && (nxt_sel == '0);

  logic [NT-1:0] sel_ff;
  logic we_ff;
  logic rd_ff;
  logic miss_ff;
  logic [15:0] addr_ff;
  logic [DW-1:0] wdata_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_ff <= '0;
      we_ff <= 1'b0;
      rd_ff <= 1'b0;
      miss_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= '0;
    end else begin
      sel_ff <= nxt_sel;
      we_ff <= take && io_we && (nxt_sel != '0); // Reserved writes dropped
      rd_ff <= take && !io_we;
      miss_ff <= nxt_miss;
      addr_ff <= io_addr;
      wdata_ff <= io_wdata;
    end
  end

  assign tgt_sel = sel_ff;
  assign tgt_we = we_ff;
  assign tgt_addr = addr_ff;
  assign tgt_wdata = wdata_ff;
  assign io_miss = miss_ff;

  // Read return: OR of selected window data; zero when nothing selected
  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = io_decode_pkg::RD_ZERO;
    for (int i = 0; i < NT; i++) begin
      if (sel_ff[i]) begin
        rd_mux = rd_mux | tgt_rdata[i*DW +: DW];
      end
    end
  end

  logic rvalid_ff;
  logic [DW-1:0] rdata_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= io_decode_pkg::RD_ZERO;
    end else begin
      rvalid_ff <= rd_ff;
      rdata_ff <= rd_ff ? rd_mux : io_decode_pkg::RD_ZERO;
    end
  end

  assign io_rvalid = rvalid_ff;
  assign io_rdata = rdata_ff;
endmodule : io_space_address_decoder

/* File: tb/io_decoder_props.sv */
// Checker on the decoder ports: window selects, refusals, read answers.
// Assumes one clock, rst_n synchronous active low; bound onto every decoder.
`timescale 1ns/1ps
module io_decoder_props #(
  parameter bit FULL_OPTION = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic io_req,
  input wire logic io_from_dma,
  input wire logic mem_req,
  input wire logic io_we,
  input wire logic [15:0] io_addr,
  input wire logic [23:0] tgt_sel,
  input wire logic tgt_we,
  input wire logic io_rvalid,
  input wire logic [15:0] io_rdata,
  input wire logic io_miss
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_take;
    io_req && !mem_req;
  endsequence
  sequence s_rd_miss;
    s_take ##0 !io_we ##1 io_miss;
  endsequence
  property p_mem;
    io_req && mem_req |=> tgt_sel == 24'h0 && !io_miss;
  endproperty
  a_mem: assert property (p_mem) else $error("memory access decoded");
  property p_idle;
    s_take ##0 io_addr <= 16'h0004 && !io_from_dma |=> tgt_sel == 24'h000001;
  endproperty
  a_idle: assert property (p_idle) else $error("idle window");
  property p_usb;
    s_take ##0 io_addr[15] |=> tgt_sel == 24'h200000 && !io_miss;
  endproperty
  a_usb: assert property (p_usb) else $error("usb window");
  property p_dma;
    s_take ##0 io_from_dma && io_addr inside {[16'h0c00:16'h0f7f]} |=> io_miss && !tgt_sel;
  endproperty
  a_dma: assert property (p_dma) else $error("dma barred window");
  property p_spi_wr;
    s_take ##0 io_we && !io_from_dma && io_addr inside {[16'h3000:16'h300f]}
      |=> tgt_we && tgt_sel[17];
  endproperty
  a_spi_wr: assert property (p_spi_wr) else $error("spi write");
  property p_i2c_end;
    s_take ##0 io_addr == 16'h1a6d |=> io_miss;
  endproperty
  a_i2c_end: assert property (p_i2c_end) else $error("i2c end");
  property p_lcd;
    s_take ##0 io_addr == 16'h2e40 && !io_from_dma |=> tgt_sel[16] == FULL_OPTION;
  endproperty
  a_lcd: assert property (p_lcd) else $error("lcd option");
  property p_rd_miss;
    s_rd_miss |=> io_rvalid && io_rdata == 16'h0000;
  endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("miss read");
endmodule : io_decoder_props
bind io_space_address_decoder io_decoder_props #(.FULL_OPTION(FULL_OPTION)) u_props (.*);

/* File: tb/io_target_model.sv */
// Peripheral targets answering reads from the decoder's select and address.
// Assumes read data is needed combinationally while a select is high.
`timescale 1ns/1ps
module io_target_model (
  input wire logic [23:0] tgt_sel,
  input wire logic [15:0] tgt_addr,
  output logic [383:0] tgt_rdata
);
  // Every target is out of reset with clocks on
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      tgt_rdata[16*i+:16] = tgt_sel[i] ? tgt_addr ^ 16'(i * 16'h0911) : ~tgt_addr;
    end
  end
endmodule : io_target_model

/* File: tb/tb_io_space_address_decoder.sv */
// Random bench for the decoder, full and reduced options side by side.
// Assumes 8 ns clock; a monitor predicts every full-option output, and the reduced option's select and miss, from sampled inputs.
`timescale 1ns/1ps
module tb_io_space_address_decoder;
  logic clk = 1'b0, rst_n = 1'b0, io_req = 1'b0, io_from_dma = 1'b0, mem_req = 1'b0;
  logic io_we = 1'b0, tgt_we, io_rvalid, io_miss, miss_r, q1 = 0, w1 = 0, d1 = 0, r1 = 0, rd2 = 0;
  logic [15:0] io_addr = 16'h0, io_wdata = 16'h0, tgt_addr, tgt_wdata, io_rdata, a1, a2, wd1;
  logic [383:0] tgt_rdata;
  logic [23:0] sel, sel_r;
  logic [15:0] cn [24] = '{16'h0004, 16'h0c7f, 16'h0d00, 16'h0f80, 16'h1800, 16'h1820, 16'h189f,
    16'h1900, 16'h197f, 16'h1a6c, 16'h1b1f, 16'h1c00, 16'h1cff, 16'h2840, 16'h2b41, 16'h2e40,
    16'h300f, 16'h3a1f, 16'h3b00, 16'h3b2f, 16'h70ff, 16'h7000, 16'h8000, 16'hffff};
  int failures = 0, checked = 0, t, t2, tr;
  bit started = 0;
  always #4 clk = ~clk;
  io_space_address_decoder #(.FULL_OPTION(1'b1)) dut (.clk, .rst_n, .io_req, .io_from_dma,
    .mem_req, .io_we, .io_addr, .io_wdata, .tgt_rdata, .tgt_sel(sel), .tgt_we, .tgt_addr,
    .tgt_wdata, .io_rvalid, .io_rdata, .io_miss);
  io_space_address_decoder #(.FULL_OPTION(1'b0)) dut_red (.clk, .rst_n, .io_req, .io_from_dma,
    .mem_req, .io_we, .io_addr, .io_wdata, .tgt_rdata, .tgt_sel(sel_r), .tgt_we(), .tgt_addr(),
    .tgt_wdata(), .io_rvalid(), .io_rdata(), .io_miss(miss_r));
  io_target_model tgt (.tgt_sel(sel), .tgt_addr(tgt_addr), .tgt_rdata(tgt_rdata));
  function automatic int exp_idx(logic [15:0] a, logic d, bit full);
    logic [15:0] lo [8] = '{16'h1900, 16'h1a00, 16'h1b00, 16'h1c00, 16'h2e00, 16'h3000, 16'h7000, 16'h8000};
    logic [15:0] hi [8] = '{16'h197f, 16'h1a6c, 16'h1b1f, 16'h1cff, 16'h2e40, 16'h300f, 16'h70ff, 16'hffff};
    int ix [8] = '{8, 9, 10, 11, 16, 17, 20, 21};
    int r = (a <= 16'h0004) ? 0 : -1;
    for (int k = 0; k < 8; k++) begin
      if (k < 4 && a >= 16'h0c00 + k * 256 && a <= 16'h0c7f + k * 256) r = 1 + k;
      if (k < 3 && a >= 16'h1800 + k * 64 && a <= 16'h181f + k * 64) r = 5 + k;
      if (k < 4 && a >= 16'h2800 + k * 256 && a <= 16'h2840 + k * 256) r = 12 + k;
      if (k < 2 && a >= 16'h3a00 + k * 256 && a <= 16'h3a1f + k * 256) r = 18 + k;
      if (a >= lo[k] && a <= hi[k]) r = ix[k];
    end
    if (!full && (r == 16 || r == 20)) r = -1;
    if (d && !(r inside {9, 10, [12:15], [18:21]})) r = -1;
    return r;
  endfunction : exp_idx
  task automatic chk(logic [31:0] g, logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("counts checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    t = q1 ? exp_idx(a1, d1, 1'b1) : -2;
    tr = q1 ? exp_idx(a1, d1, 1'b0) : -2;
    if (started) begin
      chk(sel, t >= 0 ? 24'h1 << t : 24'h0);
      chk(io_miss, q1 && t < 0);
      chk(tgt_we, t >= 0 && w1);
      chk(sel_r, tr >= 0 ? 24'h1 << tr : 24'h0);
      chk(miss_r, q1 && tr < 0);
      chk({tgt_addr, tgt_wdata}, r1 ? {a1, wd1} : 32'h0);
      chk(io_rvalid, rd2);
      if (rd2) chk(io_rdata, t2 < 0 ? 16'h0 : a2 ^ 16'(t2 * 16'h0911));
    end
    started = 1;
    rd2 = q1 && !w1 && rst_n;
    {t2, a2, r1, a1, w1, d1, wd1} = {t, a1, rst_n, io_addr, io_we, io_from_dma, io_wdata};
    q1 = io_req && !mem_req && rst_n;
  end
  initial begin
    void'($urandom(98873));
    repeat (10) @(posedge clk);
    $display("test reset done");
    for (int n = 0; n < 4000; n++) begin
      // Reserved and barred addresses are driven on purpose to see refusal
      rst_n <= !(n inside {[2000:2002]});
      io_req <= ($urandom % 4) != 0;
      mem_req <= ($urandom % 8) == 0;
      io_from_dma <= $urandom % 2;
      io_we <= $urandom % 2;
      io_wdata <= 16'($urandom);
      io_addr <= ($urandom % 2) ? 16'($urandom) : cn[$urandom % 24] + 16'($urandom % 3) - 16'h1;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
    $display("test random done");
    print_verdict();
  end
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
endmodule : tb_io_space_address_decoder
